// file: core/vcx_pkg.sv
package vcx_pkg;

    localparam int N_PORT = 4;
    localparam int PW     = 2;

    localparam logic [7:0] ADDR_ROUTE  = 8'h00;
    localparam logic [7:0] ADDR_PROT   = 8'h04;
    localparam logic [7:0] ADDR_TIMES  = 8'h08;
    localparam logic [7:0] ADDR_CMD    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_COMMIT = 8'h14;

    localparam int ROUTE_STRIDE = 4;
    localparam int ROUTE_EN_BIT = 3;
    localparam logic [15:0] ROUTE_RST = 16'h0000;
    localparam logic [15:0] PROT_RST  = 16'h0000;

    localparam int WTR_LSB  = 0;
    localparam int WTR_W    = 4;
    localparam int HOLD_LSB = 8;
    localparam int HOLD_W   = 7;
    localparam logic [3:0] WTR_RST  = 4'h5;
    localparam logic [6:0] HOLD_RST = 7'h00;

    localparam int CMD_TGT_BIT = 2;
    localparam int COMMIT_BIT  = 0;

    localparam int CLK_NS      = 50;
    localparam int MS_NS       = 1000000;
    localparam int TICK_MS_CYC = MS_NS / CLK_NS;
    localparam int HOLD_STEP_MS = 100;
    localparam int WTR_UNIT_MS  = 60000;
    localparam int WTR_CW       = 20;
    localparam int HOLD_CW      = 14;
    localparam int FRAME_BYTES  = 104;

    typedef struct packed {
        logic [7:0] data;
        logic       fs;
        logic       ssf;
    } vcx_stream_t;

    typedef enum logic [1:0] {
        KIND_UNPROT,
        KIND_INHERENT,
        KIND_NONINTR,
        KIND_SUBLAYER
    } vcx_kind_t;

    typedef enum logic [1:0] {
        CMD_CLEAR,
        CMD_LOCKOUT,
        CMD_FORCED,
        CMD_MANUAL
    } vcx_cmd_t;

    typedef struct packed {
        logic [PW-1:0] normal_in;
        logic [PW-1:0] prot_out;
        logic [PW-1:0] work_out;
        logic [PW-1:0] normal_out;
        logic [PW-1:0] prot_in;
        logic [PW-1:0] work_in;
        logic          revertive;
        logic          bidir;
        vcx_kind_t     kind;
    } vcx_prot_cfg_t;

endpackage : vcx_pkg

// file: core/vcx_cond_filter.sv
`timescale 1ns/1ns
module vcx_cond_filter
    import vcx_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Raw conditions from outside this domain
    input  wire logic              ssf_raw,
    input  wire logic              tsf_raw,
    input  wire logic              tsd_raw,
    // Settings
    input  wire vcx_kind_t         kind,
    input  wire logic [HOLD_W-1:0] hold_steps,
    input  wire logic              ms_tick,
    // Held-off criteria
    output logic                   sf,
    output logic                   sd
);

    logic [2:0]         st1;
    logic [2:0]         st2;
    logic [2:0]         st3;
    logic [2:0]         stable;
    logic [1:0]         cond;
    logic [1:0]         eff;
    logic [HOLD_CW-1:0] cnt [2];
    logic [HOLD_CW-1:0] limit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st1    <= 3'h0;
            st2    <= 3'h0;
            st3    <= 3'h0;
            stable <= 3'h0;
        end else begin
            st1    <= {tsd_raw, tsf_raw, ssf_raw};
            st2    <= st1;
            st3    <= st2;
            stable <= (st2 & ~(st2 ^ st3)) | (stable & (st2 ^ st3));
        end
    end

    // The inherent variant has no degrade criterion at all.
    assign cond[0] = (kind == KIND_INHERENT) ? stable[0] : stable[1]; // RULE13
    assign cond[1] = (kind != KIND_INHERENT) & stable[2]; // RULE13
    assign limit   = HOLD_CW'(hold_steps * HOLD_STEP_MS);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eff    <= 2'h0;
            cnt[0] <= '0;
            cnt[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!cond[i]) begin
                    cnt[i] <= '0;
                    eff[i] <= 1'b0;
                end else if (cnt[i] >= limit) begin
                    eff[i] <= 1'b1; // RULE11
                end else if (ms_tick) begin
                    cnt[i] <= cnt[i] + 1'b1;
                end
            end
        end
    end

    assign sf = eff[0];
    assign sd = eff[1];

    property p_holdoff;
        @(posedge clk) disable iff (!rst_n)
        $rose(cond[0]) && limit != '0 |=> !eff[0] [*2];
    endproperty
    a_holdoff: assert property (p_holdoff) // RULE11
        else $error("fail criterion not held off");

    property p_inherent_no_degrade;
        @(posedge clk) disable iff (!rst_n)
        kind == KIND_INHERENT |=> !sd;
    endproperty
    a_inherent_no_degrade: assert property (p_inherent_no_degrade) // RULE13
        else $error("degrade used by inherent variant");

endmodule : vcx_cond_filter

// file: core/vcx_cross_connect.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Management connects one input to one output.
// RULE2 - Management can remove any existing connection.
// RULE3 - Connection has protection kind and direction.
// RULE4 - Broadcast is several connections from one input.
// RULE5 - Configuration changes never disturb passing traffic.
// RULE6 - Generate unequipped signal framed to timing inputs.
// RULE7 - Unconnected outputs carry unequipped, valid frame, no fail.
// RULE8 - Protected sink selects working or protection input.
// RULE9 - Protected source bridges normal input to both.
// RULE10 - Revertive waits restore time; non-revertive stays.
// RULE11 - New fail or degrade held off first.
// RULE12 - Lockout, forced, manual, clear; non-revertive names target.
// RULE13 - Protection kind chooses fail and degrade criteria.
// RULE14 - Switch completes well within fifty milliseconds.
// RULE15 - Single-ended switching; fail and degrade high priority.
module vcx_cross_connect
    import vcx_pkg::*;
#(
    parameter int TICK_CYC = TICK_MS_CYC
)(
    // System clock and reset
    input  wire logic                     CLK_SYS,
    input  wire logic                     ARST_N,
    // APB slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [7:0]               PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic      [31:0]              PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    // Path streams and timing frame start on the link clock
    input  wire logic                     LINK_CLK,
    input  wire vcx_stream_t [N_PORT-1:0] IN_STREAM,
    input  wire logic                     TIMING_FS,
    output vcx_stream_t [N_PORT-1:0]      OUT_STREAM,
    // Trail conditions per input
    input  wire logic [N_PORT-1:0]        TRAIL_SIGNAL_FAIL,
    input  wire logic [N_PORT-1:0]        TRAIL_SIGNAL_DEGRADE
);

    localparam int MS_CW = $clog2(TICK_CYC + 1);
    localparam logic [MS_CW-1:0] MS_LAST = MS_CW'(TICK_CYC - 1);
    localparam logic [6:0] FRAME_LAST = 7'(FRAME_BYTES - 1);

    function automatic logic route_en(input logic [15:0] r, input int o);
        route_en = r[o * ROUTE_STRIDE + ROUTE_EN_BIT];
    endfunction : route_en

    function automatic logic [PW-1:0] route_src(input logic [15:0] r, input int o);
        route_src = r[o * ROUTE_STRIDE +: PW];
    endfunction : route_src

    logic [15:0]       route_reg;
    vcx_prot_cfg_t     prot_cfg;
    logic [WTR_W-1:0]  wtr_min;
    logic [HOLD_W-1:0] hold_steps;
    vcx_cmd_t          cmd_code;
    logic              cmd_tgt;
    logic              commit_req;
    logic [1:0]        ack_sync;
    logic              busy;
    logic [MS_CW-1:0]  ms_cnt;
    logic              ms_tick;
    logic              sel_prot;
    logic              next_sel;
    logic              tgt_eff;
    logic              wtr_arm;
    logic              wtr_done;
    logic [WTR_CW-1:0] wtr_cnt;
    logic [WTR_CW-1:0] wtr_limit;
    logic              sf_w;
    logic              sd_w;
    logic              sf_p;
    logic              sd_p;
    logic              take;
    logic              wr_ok;
    logic              bad;
    logic [31:0]       rdata;

    logic [1:0]                  req_sync;
    logic                        req_seen;
    logic                        pend;
    logic                        ack;
    logic [15:0]                 act_route;
    vcx_prot_cfg_t               act_cfg;
    logic [1:0]                  sel_sync;
    logic [6:0]                  uneq_cnt;
    logic                        uneq_fs;
    logic                        ssf_w_link;
    logic                        ssf_p_link;
    vcx_stream_t                 uneq;
    vcx_stream_t [N_PORT-1:0]    next_out;

    // APB: the answer comes one cycle into the access phase.
    assign take  = PSEL & PENABLE & PREADY;
    assign wr_ok = take & PWRITE & ~PSLVERR;
    assign busy  = commit_req ^ ack_sync[1];

    // Routing and protection words may not change while a commit is in flight.
    always_comb begin
        bad = 1'b0;
        unique case (PADDR)
            ADDR_ROUTE, ADDR_PROT, ADDR_COMMIT: bad = PWRITE & busy;
            ADDR_TIMES, ADDR_CMD, ADDR_STATUS:  bad = 1'b0;
            default:                            bad = 1'b1;
        endcase
    end

    always_comb begin
        rdata = 32'h00000000;
        unique case (PADDR)
            ADDR_ROUTE:  rdata[15:0] = route_reg;
            ADDR_PROT:   rdata[15:0] = prot_cfg;
            ADDR_TIMES:  rdata = {17'h00000, hold_steps, 4'h0, wtr_min};
            ADDR_CMD:    rdata[2:0] = {cmd_tgt, cmd_code};
            ADDR_STATUS: rdata[6:0] = {busy, wtr_arm, sd_p, sd_w, sf_p, sf_w, sel_prot};
            ADDR_COMMIT: rdata[0] = busy;
            default:     rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & bad;
            PRDATA  <= (PSEL & PENABLE & ~PREADY & ~PWRITE & ~bad) ? rdata : 32'h00000000;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            route_reg  <= ROUTE_RST;
            prot_cfg   <= vcx_prot_cfg_t'(PROT_RST);
            wtr_min    <= WTR_RST;
            hold_steps <= HOLD_RST;
            cmd_code   <= CMD_CLEAR;
            cmd_tgt    <= 1'b0;
            commit_req <= 1'b0;
        end else if (wr_ok) begin
            unique case (PADDR)
                ADDR_ROUTE:  route_reg <= PWDATA[15:0]; // RULE1 RULE2 RULE4
                ADDR_PROT:   prot_cfg <= vcx_prot_cfg_t'(PWDATA[15:0]); // RULE3
                ADDR_TIMES: begin
                    wtr_min    <= PWDATA[WTR_LSB +: WTR_W];
                    hold_steps <= PWDATA[HOLD_LSB +: HOLD_W];
                end
                ADDR_CMD: begin
                    cmd_code <= vcx_cmd_t'(PWDATA[1:0]); // RULE12
                    cmd_tgt  <= PWDATA[CMD_TGT_BIT];
                end
                ADDR_COMMIT: commit_req <= commit_req ^ PWDATA[COMMIT_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_sync <= 2'h0;
        end else begin
            ack_sync <= {ack_sync[0], ack};
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == MS_LAST);
            ms_cnt  <= (ms_cnt == MS_LAST) ? '0 : ms_cnt + 1'b1;
        end
    end

    vcx_cond_filter u_work (
        .clk        (CLK_SYS),
        .rst_n      (ARST_N),
        .ssf_raw    (ssf_w_link),
        .tsf_raw    (TRAIL_SIGNAL_FAIL[prot_cfg.work_in]),
        .tsd_raw    (TRAIL_SIGNAL_DEGRADE[prot_cfg.work_in]),
        .kind       (prot_cfg.kind),
        .hold_steps (hold_steps),
        .ms_tick    (ms_tick),
        .sf         (sf_w),
        .sd         (sd_w)
    );

    vcx_cond_filter u_prot (
        .clk        (CLK_SYS),
        .rst_n      (ARST_N),
        .ssf_raw    (ssf_p_link),
        .tsf_raw    (TRAIL_SIGNAL_FAIL[prot_cfg.prot_in]),
        .tsd_raw    (TRAIL_SIGNAL_DEGRADE[prot_cfg.prot_in]),
        .kind       (prot_cfg.kind),
        .hold_steps (hold_steps),
        .ms_tick    (ms_tick),
        .sf         (sf_p),
        .sd         (sd_p)
    );

    // Revertive operation only knows a switch to protection as a command target.
    assign tgt_eff   = prot_cfg.revertive | cmd_tgt; // RULE12
    assign wtr_limit = WTR_CW'(wtr_min * WTR_UNIT_MS);
    assign wtr_done  = wtr_cnt >= wtr_limit;
    assign wtr_arm   = prot_cfg.kind != KIND_UNPROT && prot_cfg.revertive && sel_prot
                       && cmd_code == CMD_CLEAR && !sf_w && !sd_w;

    // Local decision only: no signalling channel to the far end exists.
    always_comb begin
        next_sel = sel_prot;
        if (prot_cfg.kind == KIND_UNPROT || cmd_code == CMD_LOCKOUT) begin
            next_sel = 1'b0;
        end else if (cmd_code == CMD_FORCED) begin
            next_sel = tgt_eff;
        end else if (sf_w != sf_p) begin
            next_sel = sf_w; // RULE15
        end else if (!sf_w && sd_w != sd_p) begin
            next_sel = sd_w; // RULE15
        end else if (cmd_code == CMD_MANUAL) begin
            next_sel = tgt_eff;
        end else if (wtr_arm && wtr_done) begin
            next_sel = 1'b0; // RULE10
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            sel_prot <= 1'b0;
            wtr_cnt  <= '0;
        end else begin
            sel_prot <= next_sel; // RULE8 RULE14
            if (!wtr_arm) begin
                wtr_cnt <= '0;
            end else if (ms_tick && !wtr_done) begin
                wtr_cnt <= wtr_cnt + 1'b1; // RULE10
            end
        end
    end

    // Link domain: commit handshake, generator and the matrix itself.
    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_sync  <= 2'h0;
            req_seen  <= 1'b0;
            pend      <= 1'b0;
            ack       <= 1'b0;
            act_route <= ROUTE_RST;
            act_cfg   <= vcx_prot_cfg_t'(PROT_RST);
        end else begin
            req_sync <= {req_sync[0], commit_req};
            req_seen <= req_sync[1];
            if (pend && uneq_fs) begin
                act_route <= route_reg; // RULE5
                act_cfg   <= prot_cfg; // RULE5
                ack       <= req_seen;
                pend      <= 1'b0;
            end else if (req_sync[1] != req_seen) begin
                pend <= 1'b1;
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            uneq_cnt <= 7'h00;
            uneq_fs  <= 1'b0;
        end else begin
            uneq_fs  <= TIMING_FS | (uneq_cnt == FRAME_LAST); // RULE6
            uneq_cnt <= (TIMING_FS || uneq_cnt == FRAME_LAST) ? 7'h00 : uneq_cnt + 1'b1;
        end
    end

    assign uneq = '{data: 8'h00, fs: uneq_fs, ssf: 1'b0};

    always_comb begin
        next_out = '0;
        for (int o = 0; o < N_PORT; o++) begin
            next_out[o] = route_en(act_route, o) ? IN_STREAM[route_src(act_route, o)] : uneq; // RULE7
        end
        if (act_cfg.kind != KIND_UNPROT) begin
            next_out[act_cfg.normal_out] = sel_sync[1] ? IN_STREAM[act_cfg.prot_in]
                                                       : IN_STREAM[act_cfg.work_in]; // RULE8
            if (act_cfg.bidir) begin
                next_out[act_cfg.work_out] = IN_STREAM[act_cfg.normal_in]; // RULE9
                next_out[act_cfg.prot_out] = IN_STREAM[act_cfg.normal_in]; // RULE9
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel_sync   <= 2'h0;
            ssf_w_link <= 1'b0;
            ssf_p_link <= 1'b0;
            OUT_STREAM <= '0;
        end else begin
            sel_sync   <= {sel_sync[0], sel_prot};
            ssf_w_link <= IN_STREAM[act_cfg.work_in].ssf;
            ssf_p_link <= IN_STREAM[act_cfg.prot_in].ssf;
            OUT_STREAM <= next_out;
        end
    end

    sequence s_route_write;
        PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == ADDR_ROUTE;
    endsequence

    property p_route_write;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        s_route_write |=> route_reg == $past(PWDATA[15:0]);
    endproperty
    a_route_write: assert property (p_route_write) // RULE1
        else $error("route write not stored");

    property p_lockout;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        cmd_code == CMD_LOCKOUT |=> !sel_prot;
    endproperty
    a_lockout: assert property (p_lockout) // RULE12
        else $error("lockout left protection selected");

    sequence s_work_fails;
        prot_cfg.kind != KIND_UNPROT && sf_w && !sf_p
        && (cmd_code == CMD_CLEAR || cmd_code == CMD_MANUAL);
    endsequence

    property p_fail_switch;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        s_work_fails |-> ##[1:2] sel_prot;
    endproperty
    a_fail_switch: assert property (p_fail_switch) // RULE14
        else $error("no switch on working fail");

    property p_wtr;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        $fell(sel_prot) && $past(cmd_code == CMD_CLEAR && !sf_p && !sd_p
        && prot_cfg.revertive && prot_cfg.kind != KIND_UNPROT) |-> $past(wtr_done);
    endproperty
    a_wtr: assert property (p_wtr) // RULE10
        else $error("reverted before restore time");

    property p_nonrevert;
        @(posedge CLK_SYS) disable iff (!ARST_N)
        sel_prot && !sf_p && !sd_p && !prot_cfg.revertive && cmd_code == CMD_CLEAR
        && prot_cfg.kind != KIND_UNPROT |=> sel_prot;
    endproperty
    a_nonrevert: assert property (p_nonrevert) // RULE10
        else $error("non-revertive selector reverted");

    property p_commit_frame;
        @(posedge LINK_CLK) disable iff (!ARST_N)
        $changed(act_route) |-> $past(uneq_fs);
    endproperty
    a_commit_frame: assert property (p_commit_frame) // RULE5
        else $error("routing changed off frame start");

    property p_timing_frame;
        @(posedge LINK_CLK) disable iff (!ARST_N)
        TIMING_FS |=> uneq_fs && uneq_cnt == 7'h00;
    endproperty
    a_timing_frame: assert property (p_timing_frame) // RULE6
        else $error("generator not framed to timing");

    property p_unequipped;
        @(posedge LINK_CLK) disable iff (!ARST_N)
        !route_en(act_route, 0) && act_cfg.kind == KIND_UNPROT |=> OUT_STREAM[0].ssf == 1'b0
        && OUT_STREAM[0].data == 8'h00 && OUT_STREAM[0].fs == $past(uneq_fs);
    endproperty
    a_unequipped: assert property (p_unequipped) // RULE7
        else $error("free output not unequipped");

    property p_bridge;
        @(posedge LINK_CLK) disable iff (!ARST_N)
        act_cfg.kind != KIND_UNPROT && act_cfg.bidir
        |=> OUT_STREAM[$past(act_cfg.prot_out)] == $past(IN_STREAM[act_cfg.normal_in]);
    endproperty
    a_bridge: assert property (p_bridge) // RULE9
        else $error("source bridge broken");

    property p_select;
        @(posedge LINK_CLK) disable iff (!ARST_N)
        act_cfg.kind != KIND_UNPROT && !act_cfg.bidir |=> OUT_STREAM[$past(act_cfg.normal_out)]
        == $past(sel_sync[1] ? IN_STREAM[act_cfg.prot_in] : IN_STREAM[act_cfg.work_in]);
    endproperty
    a_select: assert property (p_select) // RULE8
        else $error("normal output not selected input");

endmodule : vcx_cross_connect

// file: dv/vcx_path_source.sv
`timescale 1ns/1ns
module vcx_path_source
    import vcx_pkg::*;
(
    // Link clock
    input  wire logic                     link_clk,
    // Fail requests per input
    input  wire logic [N_PORT-1:0]        ssf_req,
    // Streams and timing towards the matrix
    output vcx_stream_t [N_PORT-1:0]      stream,
    output logic                          timing_fs
);
    logic [7:0] byte_cnt = 8'h00;

    // Each input carries its own byte ramp so a wrong route shows at once.
    always_ff @(posedge link_clk) begin
        byte_cnt  <= (byte_cnt == 8'(FRAME_BYTES - 1)) ? 8'h00 : byte_cnt + 8'h01;
        timing_fs <= (byte_cnt == 8'(FRAME_BYTES - 1));
        for (int p = 0; p < N_PORT; p++) begin
            stream[p].data <= byte_cnt + 8'(p * 64);
            stream[p].fs   <= (byte_cnt == 8'(FRAME_BYTES - 1));
            stream[p].ssf  <= ssf_req[p];
        end
    end
endmodule : vcx_path_source

// file: dv/vcx_cross_connect_test.sv
`timescale 1ns/1ns
module vcx_cross_connect_test;
    import vcx_pkg::*;
    logic                      clk_sys = 1'b0;
    logic                      link_clk = 1'b0;
    logic                      arst_n = 1'b0;
    logic                      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]                paddr = 8'h00;
    logic [31:0]               pwdata = 32'h0, prdata, rd;
    logic                      pready, pslverr, err;
    vcx_stream_t [N_PORT-1:0]  in_s, out_s;
    logic                      timing_fs;
    logic [N_PORT-1:0]         ssf_req = '0, tsf = '0, tsd = '0;
    int                        n_errors = 0, samples_checked = 0, cnt;

    always #25 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    vcx_cross_connect #(.TICK_CYC(10)) vcx_cross_connect_inst (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LINK_CLK(link_clk), .IN_STREAM(in_s),
        .TIMING_FS(timing_fs), .OUT_STREAM(out_s), .TRAIL_SIGNAL_FAIL(tsf),
        .TRAIL_SIGNAL_DEGRADE(tsd));
    vcx_path_source vcx_path_source_inst (
        .link_clk(link_clk), .ssf_req(ssf_req), .stream(in_s), .timing_fs(timing_fs));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until PREADY is seen high at a rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (pready !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, pready, 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Commit only lands on a frame boundary, so busy is polled, not timed.
    task commit();
        int n;
        n = 0;
        apb(1'b1, ADDR_COMMIT, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        while (rd[6] !== 1'b0 && n < 300) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        chk({31'h0, rd[6]}, 32'h0);
    endtask : commit

    // The fail flag is captured with its byte, since the source may move it meanwhile.
    task stm(input int o, input int i);
        logic [8:0] d;
        @(posedge link_clk);
        d = {in_s[i].data, in_s[i].ssf};
        @(posedge link_clk);
        chk({24'h0, out_s[o].data}, {24'h0, d[8:1]});
        chk({31'h0, out_s[o].ssf}, {31'h0, d[0]});
    endtask : stm

    task sel(input logic exp, input int polls);
        int n;
        n = 0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        while (rd[0] !== exp && n < polls) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        chk({31'h0, rd[0]}, {31'h0, exp});
    endtask : sel

    task test_done();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    initial begin
        #3000000;
        n_errors++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, ADDR_TIMES, 32'h0);
        chk(rd, {17'h0, HOLD_RST, 4'h0, WTR_RST} & 32'h7F0F);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("Register reset test done");
        cnt = 0;
        repeat (220) begin
            @(posedge link_clk);
            cnt += int'(out_s[2].fs);
            chk({23'h0, out_s[2].data, out_s[2].ssf}, 32'h0);
        end
        chk(32'(cnt >= 2), 32'h1);
        $display("Unequipped test done");
        apb(1'b1, ADDR_ROUTE, 32'h00AA);
        commit();
        stm(0, 2);
        stm(1, 2);
        ssf_req[2] <= 1'b1;
        repeat (4) @(posedge link_clk);
        stm(0, 2);
        ssf_req[2] <= 1'b0;
        apb(1'b1, ADDR_TIMES, 32'h0009);
        stm(1, 2);
        apb(1'b1, ADDR_ROUTE, 32'h0000);
        commit();
        @(posedge link_clk);
        chk({31'h0, out_s[0].ssf}, 32'h0);
        chk({24'h0, out_s[1].data}, 32'h0);
        chk({24'h0, out_s[0].data}, 32'h0);
        $display("Routing test done");
        apb(1'b1, ADDR_PROT, 32'h0341);
        commit();
        stm(3, 0);
        ssf_req[0] <= 1'b1;
        sel(1'b1, 100);
        stm(3, 1);
        ssf_req[0] <= 1'b0;
        repeat (200) @(posedge clk_sys);
        sel(1'b1, 0);
        apb(1'b1, ADDR_CMD, 32'h2);
        sel(1'b0, 100);
        stm(3, 0);
        apb(1'b1, ADDR_CMD, 32'h7);
        sel(1'b1, 100);
        apb(1'b1, ADDR_CMD, 32'h1);
        sel(1'b0, 100);
        apb(1'b1, ADDR_CMD, 32'h0);
        $display("Selector test done");
        apb(1'b1, ADDR_TIMES, 32'h0105);
        apb(1'b1, ADDR_PROT, 32'h0342);
        commit();
        tsf[0] <= 1'b1;
        repeat (300) @(posedge clk_sys);
        sel(1'b0, 0);
        sel(1'b1, 600);
        $display("Hold-off test done");
        apb(1'b1, ADDR_TIMES, 32'h0000);
        apb(1'b1, ADDR_PROT, 32'hE74E);
        commit();
        stm(1, 3);
        stm(2, 3);
        stm(3, 1);
        tsf[0] <= 1'b0;
        sel(1'b0, 100);
        stm(3, 0);
        tsd[0] <= 1'b1;
        sel(1'b1, 100);
        tsd[0] <= 1'b0;
        sel(1'b0, 100);
        $display("Bridge and revertive test done");
        test_done();
    end
endmodule : vcx_cross_connect_test
